// file: rtl/dbg_serial_pkg.sv
// Constants, field layouts and state carriers of the debug serial port
package dbg_serial_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_IRQ_SET = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
  localparam logic [7:0] OFF_IMASK = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_RXH = 8'h18;
  localparam logic [7:0] OFF_TXH = 8'h1C;
  localparam logic [7:0] OFF_BAUD = 8'h20;
  localparam logic [7:0] OFF_CID = 8'h40;
  localparam logic [7:0] OFF_CID_EXT = 8'h44;
  localparam logic [7:0] OFF_LOCK = 8'h48;

  // ==========================================================
  // Command bit positions
  localparam int CMD_RX_RESET = 2;
  localparam int CMD_TX_RESET = 3;
  localparam int CMD_RX_ON = 4;
  localparam int CMD_RX_OFF = 5;
  localparam int CMD_TX_ON = 6;
  localparam int CMD_TX_OFF = 7;
  localparam int CMD_CLR_ERR = 8;

  // ==========================================================
  // Config field positions and reset values
  localparam int CFG_CHECK_LSB = 9;
  localparam int CFG_LOOP_LSB = 14;
  localparam logic [2:0] CHECK_RESET = 3'h0;
  localparam logic [15:0] CD_RESET = 16'h0000;
  localparam logic [31:0] IMASK_RESET = 32'h0000_0000;

  // ==========================================================
  // Status and interrupt source positions
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_TX_FREE = 1;
  localparam int ST_RX_XFER = 3;
  localparam int ST_TX_XFER = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAME = 6;
  localparam int ST_CHECK = 7;
  localparam int ST_TX_IDLE = 9;
  localparam int ST_TX_BUFE = 11;
  localparam int ST_RX_BUFF = 12;
  localparam int ST_DCC_CORE = 30;
  localparam int ST_DCC_HOST = 31;
  localparam logic [31:0] IRQ_VALID = 32'hC000_1AFB;

  // ==========================================================
  // Bit timing
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_CENTER = 4'h7;
  localparam logic [3:0] TX_BITS_CHECK = 4'hB;
  localparam logic [3:0] TX_BITS_PLAIN = 4'hA;
  localparam logic [3:0] RX_BITS_CHECK = 4'h9;
  localparam logic [3:0] RX_BITS_PLAIN = 4'h8;

  // ==========================================================
  // Enumerations and state carriers
  typedef enum logic [1:0] {
    LOOP_NORMAL = 2'h0,
    LOOP_ECHO = 2'h1,
    LOOP_LOCAL = 2'h2,
    LOOP_REMOTE = 2'h3
  } loop_mode_t;

  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3,
    RX_STOP = 2'h2
  } rx_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } baud_state_t;

  typedef struct packed {
    logic rx_en;
    logic rx_stop_pend;
    logic tx_en;
    logic tx_stop_pend;
    logic [2:0] check_type;
    loop_mode_t loop_select;
    logic [15:0] cd;
    logic [31:0] imask;
    logic overrun_flag;
    logic frame_flag;
    logic check_bit_err_flag;
    logic rx_char_avail;
    logic [7:0] rx_data;
    logic [7:0] thr;
    logic thr_full;
    tx_state_t tx_state;
    logic [3:0] tx_sub;
    logic [3:0] tx_left;
    logic [10:0] tx_sh;
    logic tx_line;
    rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic [31:0] rdata;
    logic slverr;
  } serial_state_t;

endpackage

// file: rtl/baud_tick_gen.sv
// Sixteen-times-oversampling tick divider for the serial port
`timescale 1ns/1ps
module baud_tick_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] cd,
  output logic tick
);
  import dbg_serial_pkg::*;

  baud_state_t q_ff;
  baud_state_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.tick = 1'b0;
    // A zero divider stops the tick, leaving the line frozen
    if (cd == 16'h0000) begin
      nxt_q.cnt = 16'h0000;
    end else if (q_ff.cnt >= cd - 16'h0001) begin
      nxt_q.cnt = 16'h0000;
      nxt_q.tick = 1'b1;
    end else begin
      nxt_q.cnt = q_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tick = q_ff.tick;
endmodule // baud_tick_gen

// file: rtl/debug_serial_ctrl.sv
// Debug serial port: APB register file, character engines and interrupt
// Functional notes
// [RULE_01] Receiver reset command stops and disables reception at once, dropping any character.
// [RULE_02] Transmitter reset command stops and disables transmission at once, dropping characters.
// [RULE_03] Receiver enable acts only when receiver disable is zero in that write.
// [RULE_04] Receiver disable without reset lets the current character finish first.
// [RULE_05] Transmitter enable acts only when transmitter disable is zero in that write.
// [RULE_06] Transmitter disable without reset finishes shifting and holding characters first.
// [RULE_07] Clear-errors command clears check, framing and overrun flags; zero does nothing.
// [RULE_08] Check type: even, odd, forced low, forced high, or none when top bit set.
// [RULE_09] Loop select: normal, automatic echo, local loopback, remote loopback.
// [RULE_10] Ones written to irq_set set mask bits; zeros leave them alone.
// [RULE_11] Debug-channel host flag at bit 31, core flag at bit 30.
// [RULE_12] Receive buffer full 12, transmit buffer empty 11, transfer ends 4 and 3.
// [RULE_13] Tx idle 9, check 7, framing 6, overrun 5, holding free 1, char 0.
// [RULE_14] Ones written to irq_clear clear mask bits; zeros do nothing.
// [RULE_15] Error flags stay set until a clear-errors command.
// [RULE_16] Tx idle high only when nothing held or shifting, low while disabled.
// [RULE_17] Character: low start, eight data bits LSB first, optional check, high stop.
// [RULE_18] Interrupt output high while any set flag has its mask bit set.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module debug_serial_ctrl #(
  // Arbitrary identification values
  parameter logic [31:0] CHIP_ID_VALUE = 32'h0A5A_0001,
  parameter logic [31:0] CHIP_ID_EXT_VALUE = 32'h0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic rx_xfer_done,
  input wire logic tx_xfer_done,
  input wire logic tx_buf_drained,
  input wire logic rx_buf_filled,
  input wire logic dcc_host_wrote,
  input wire logic dcc_core_wrote,
  output logic irq
);
  import dbg_serial_pkg::*;

  // ==========================================================
  // Helper functions
  function automatic logic check_bit(input logic [7:0] d, input logic [2:0] t);
    case (t[1:0]) // [RULE_08]
      2'h0: check_bit = ^d;
      2'h1: check_bit = ~^d;
      2'h2: check_bit = 1'b0;
      default: check_bit = 1'b1;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      OFF_CMD, OFF_CFG, OFF_IRQ_SET, OFF_IRQ_CLR, OFF_IMASK, OFF_FLAGS,
      OFF_RXH, OFF_TXH, OFF_BAUD, OFF_CID, OFF_CID_EXT, OFF_LOCK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  serial_state_t q_ff;
  serial_state_t nxt_q;
  logic tick;
  logic [31:0] status;
  logic rx_line;
  logic rx_run;
  logic tx_run;
  logic check_on;
  logic acc_wr;
  logic acc_rd;
  logic setup;
  logic [7:0] rx_byte;
  logic [31:0] cmd;

  baud_tick_gen u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .cd(q_ff.cd),
    .tick(tick)
  );

  // ==========================================================
  // Status vector
  always_comb begin
    status = 32'h0000_0000;
    status[ST_RX_AVAIL] = q_ff.rx_char_avail; // [RULE_13]
    status[ST_TX_FREE] = q_ff.tx_en & ~q_ff.thr_full; // [RULE_13]
    status[ST_RX_XFER] = rx_xfer_done; // [RULE_12]
    status[ST_TX_XFER] = tx_xfer_done; // [RULE_12]
    status[ST_OVERRUN] = q_ff.overrun_flag; // [RULE_13]
    status[ST_FRAME] = q_ff.frame_flag; // [RULE_13]
    status[ST_CHECK] = q_ff.check_bit_err_flag; // [RULE_13]
    status[ST_TX_IDLE] = q_ff.tx_en & ~q_ff.thr_full & (q_ff.tx_state == TX_IDLE); // [RULE_16]
    status[ST_TX_BUFE] = tx_buf_drained; // [RULE_12]
    status[ST_RX_BUFF] = rx_buf_filled; // [RULE_12]
    status[ST_DCC_CORE] = dcc_core_wrote; // [RULE_11]
    status[ST_DCC_HOST] = dcc_host_wrote; // [RULE_11]
  end

  // ==========================================================
  // Line routing per loop mode
  always_comb begin
    // Local loopback feeds the receiver from our own shifter
    rx_line = (q_ff.loop_select == LOOP_LOCAL) ? q_ff.tx_line : serial_in_pin; // [RULE_09]
    // Remote loopback keeps both engines out of the way
    rx_run = q_ff.rx_en & (q_ff.loop_select != LOOP_REMOTE);
    tx_run = q_ff.tx_en & (q_ff.loop_select != LOOP_REMOTE);
    check_on = ~q_ff.check_type[2]; // [RULE_08]
    rx_byte = check_on ? q_ff.rx_sh[7:0] : q_ff.rx_sh[8:1];
    setup = psel & ~penable;
    acc_wr = psel & penable & pwrite;
    acc_rd = psel & penable & ~pwrite;
    cmd = (acc_wr && paddr == OFF_CMD) ? pwdata : 32'h0000_0000;
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_q = q_ff;

    // Clear first so an error caught in this cycle still sets
    if (cmd[CMD_CLR_ERR]) begin
      nxt_q.overrun_flag = 1'b0; // [RULE_07]
      nxt_q.frame_flag = 1'b0; // [RULE_07]
      nxt_q.check_bit_err_flag = 1'b0; // [RULE_07]
    end
    if (acc_rd && paddr == OFF_RXH) begin
      nxt_q.rx_char_avail = 1'b0;
    end

    // Plain register writes
    if (acc_wr) begin
      case (paddr)
        OFF_CFG: begin
          nxt_q.check_type = pwdata[CFG_CHECK_LSB +: 3];
          nxt_q.loop_select = loop_mode_t'(pwdata[CFG_LOOP_LSB +: 2]);
        end
        OFF_IRQ_SET: nxt_q.imask = q_ff.imask | (pwdata & IRQ_VALID); // [RULE_10]
        OFF_IRQ_CLR: nxt_q.imask = q_ff.imask & ~pwdata; // [RULE_14]
        OFF_BAUD: nxt_q.cd = pwdata[15:0];
        OFF_TXH: begin
          // Writes while disabled are dropped
          if (q_ff.tx_en) begin
            nxt_q.thr = pwdata[7:0];
            nxt_q.thr_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Transmit engine
    case (q_ff.tx_state)
      TX_IDLE: begin
        nxt_q.tx_line = 1'b1;
        if (tx_run && q_ff.thr_full) begin
          // A character written in the load cycle stays held, not lost
          nxt_q.thr_full = acc_wr && paddr == OFF_TXH;
          nxt_q.tx_state = TX_SHIFT;
          nxt_q.tx_sub = 4'h0;
          nxt_q.tx_sh = {1'b1, check_on ? check_bit(q_ff.thr, q_ff.check_type) : 1'b1,
                         q_ff.thr, 1'b0}; // [RULE_17]
          nxt_q.tx_left = check_on ? TX_BITS_CHECK : TX_BITS_PLAIN;
          nxt_q.tx_line = 1'b0; // [RULE_17]
        end else if (q_ff.tx_stop_pend && !q_ff.thr_full) begin
          nxt_q.tx_en = 1'b0; // [RULE_06]
          nxt_q.tx_stop_pend = 1'b0;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          if (q_ff.tx_sub == SUB_LAST) begin
            nxt_q.tx_sub = 4'h0;
            if (q_ff.tx_left == 4'h1) begin
              nxt_q.tx_state = TX_IDLE;
              nxt_q.tx_line = 1'b1;
            end else begin
              nxt_q.tx_sh = {1'b1, q_ff.tx_sh[10:1]}; // [RULE_17]
              nxt_q.tx_line = q_ff.tx_sh[1];
              nxt_q.tx_left = q_ff.tx_left - 4'h1;
            end
          end else begin
            nxt_q.tx_sub = q_ff.tx_sub + 4'h1;
          end
        end
      end
      default: nxt_q.tx_state = TX_IDLE;
    endcase

    // Receive engine, sampling each bit at its centre
    if (tick) begin
      case (q_ff.rx_state)
        RX_IDLE: begin
          if (rx_run && !rx_line) begin
            nxt_q.rx_state = RX_START;
            nxt_q.rx_sub = 4'h0;
          end
        end
        RX_START: begin
          if (q_ff.rx_sub == SUB_CENTER) begin
            // A glitch shorter than half a bit is not a start
            nxt_q.rx_state = rx_line ? RX_IDLE : RX_DATA; // [RULE_17]
            nxt_q.rx_sub = 4'h0;
            nxt_q.rx_cnt = 4'h0;
          end else begin
            nxt_q.rx_sub = q_ff.rx_sub + 4'h1;
          end
        end
        RX_DATA: begin
          if (q_ff.rx_sub == SUB_LAST) begin
            nxt_q.rx_sub = 4'h0;
            nxt_q.rx_sh = {rx_line, q_ff.rx_sh[8:1]}; // [RULE_17]
            nxt_q.rx_cnt = q_ff.rx_cnt + 4'h1;
            if (q_ff.rx_cnt + 4'h1 == (check_on ? RX_BITS_CHECK : RX_BITS_PLAIN)) begin
              nxt_q.rx_state = RX_STOP;
            end
          end else begin
            nxt_q.rx_sub = q_ff.rx_sub + 4'h1;
          end
        end
        RX_STOP: begin
          if (q_ff.rx_sub == SUB_LAST) begin
            nxt_q.rx_state = RX_IDLE;
            nxt_q.rx_data = rx_byte;
            nxt_q.rx_char_avail = 1'b1;
            if (q_ff.rx_char_avail) begin
              nxt_q.overrun_flag = 1'b1; // [RULE_15]
            end
            if (!rx_line) begin
              nxt_q.frame_flag = 1'b1; // [RULE_15]
            end
            if (check_on && q_ff.rx_sh[8] != check_bit(rx_byte, q_ff.check_type)) begin
              nxt_q.check_bit_err_flag = 1'b1; // [RULE_15]
            end
            if (q_ff.rx_stop_pend) begin
              nxt_q.rx_en = 1'b0; // [RULE_04]
              nxt_q.rx_stop_pend = 1'b0;
            end
          end else begin
            nxt_q.rx_sub = q_ff.rx_sub + 4'h1;
          end
        end
        default: nxt_q.rx_state = RX_IDLE;
      endcase
    end
    if (!rx_run && q_ff.rx_state != RX_IDLE && q_ff.loop_select == LOOP_REMOTE) begin
      nxt_q.rx_state = RX_IDLE;
    end

    // Enable and disable commands
    if (cmd[CMD_RX_OFF]) begin
      if (q_ff.rx_state == RX_IDLE) begin
        nxt_q.rx_en = 1'b0;
      end else begin
        nxt_q.rx_stop_pend = 1'b1; // [RULE_04]
      end
    end else if (cmd[CMD_RX_ON]) begin
      nxt_q.rx_en = 1'b1; // [RULE_03]
      nxt_q.rx_stop_pend = 1'b0;
    end
    if (cmd[CMD_TX_OFF]) begin
      if (q_ff.tx_state == TX_IDLE && !q_ff.thr_full) begin
        nxt_q.tx_en = 1'b0;
      end else begin
        nxt_q.tx_stop_pend = 1'b1; // [RULE_06]
      end
    end else if (cmd[CMD_TX_ON]) begin
      nxt_q.tx_en = 1'b1; // [RULE_05]
      nxt_q.tx_stop_pend = 1'b0;
    end

    // Resets follow the enable commands and override the enables and engine states set above
    if (cmd[CMD_RX_RESET]) begin
      nxt_q.rx_en = 1'b0; // [RULE_01]
      nxt_q.rx_stop_pend = 1'b0;
      nxt_q.rx_state = RX_IDLE; // [RULE_01]
      nxt_q.rx_sub = 4'h0;
      nxt_q.rx_cnt = 4'h0;
    end
    if (cmd[CMD_TX_RESET]) begin
      nxt_q.tx_en = 1'b0; // [RULE_02]
      nxt_q.tx_stop_pend = 1'b0;
      nxt_q.tx_state = TX_IDLE; // [RULE_02]
      nxt_q.thr_full = 1'b0;
      nxt_q.tx_line = 1'b1;
    end

    // Read data and error answer captured in the setup cycle
    if (setup) begin
      nxt_q.slverr = ~is_mapped(paddr);
      case (paddr)
        OFF_CFG: nxt_q.rdata = {16'h0000, q_ff.loop_select, 2'h0,
                                q_ff.check_type, 9'h000};
        OFF_IMASK: nxt_q.rdata = q_ff.imask;
        OFF_FLAGS: nxt_q.rdata = status;
        OFF_RXH: nxt_q.rdata = {24'h000000, q_ff.rx_data};
        OFF_BAUD: nxt_q.rdata = {16'h0000, q_ff.cd};
        OFF_CID: nxt_q.rdata = CHIP_ID_VALUE;
        OFF_CID_EXT: nxt_q.rdata = CHIP_ID_EXT_VALUE;
        default: nxt_q.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
      q_ff.check_type <= CHECK_RESET;
      q_ff.cd <= CD_RESET;
      q_ff.imask <= IMASK_RESET;
      q_ff.tx_line <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    case (q_ff.loop_select) // [RULE_09]
      LOOP_ECHO: serial_out_pin = serial_in_pin;
      LOOP_LOCAL: serial_out_pin = 1'b1;
      LOOP_REMOTE: serial_out_pin = serial_in_pin;
      default: serial_out_pin = q_ff.tx_line;
    endcase
  end

  assign prdata = q_ff.rdata;
  assign pready = 1'b1;
  assign pslverr = q_ff.slverr;
  assign irq = |(status & q_ff.imask); // [RULE_18]
endmodule // debug_serial_ctrl

// file: dv/debug_serial_ctrl_monitor.sv
// Port-level assertions for the debug serial port
`timescale 1ns/1ps
module debug_serial_ctrl_monitor
  import dbg_serial_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic rx_buf_filled,
  input wire logic dcc_host_wrote,
  input wire logic dcc_core_wrote,
  input wire logic irq
);
  // ====
  // Shadow of mask and loop mode, rebuilt from bus writes
  logic [31:0] mask_ff;
  logic [1:0] loop_ff;
  logic wr;
  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= 32'h0;
      loop_ff <= 2'h0;
    end else if (wr && paddr == OFF_IRQ_SET) begin
      mask_ff <= mask_ff | (pwdata & IRQ_VALID);
    end else if (wr && paddr == OFF_IRQ_CLR) begin
      mask_ff <= mask_ff & ~pwdata;
    end else if (wr && paddr == OFF_CFG) begin
      loop_ff <= pwdata[CFG_LOOP_LSB+:2];
    end
  end
  // ====
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mask_read;
    psel && penable && !pwrite && paddr == OFF_IMASK |-> prdata == mask_ff;
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask view wrong");
  property p_irq_off;
    mask_ff == 32'h0 |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with no mask");
  // Input held two edges, so a registered flag copy is covered too
  property p_host;
    dcc_host_wrote && $past(dcc_host_wrote) && mask_ff[ST_DCC_HOST] |-> irq;
  endproperty
  a_host: assert property (p_host) else $error("host flag irq missing");
  property p_core;
    dcc_core_wrote && $past(dcc_core_wrote) && mask_ff[ST_DCC_CORE] |-> irq;
  endproperty
  a_core: assert property (p_core) else $error("core flag irq missing");
  property p_buff;
    rx_buf_filled && $past(rx_buf_filled) && mask_ff[ST_RX_BUFF] |-> irq;
  endproperty
  a_buff: assert property (p_buff) else $error("buffer full irq missing");
  property p_remote;
    loop_ff == LOOP_REMOTE |-> serial_out_pin == serial_in_pin;
  endproperty
  a_remote: assert property (p_remote) else $error("remote loop broken");
  property p_local;
    loop_ff == LOOP_LOCAL |-> serial_out_pin;
  endproperty
  a_local: assert property (p_local) else $error("local loop line low");
  property p_txrst;
    wr && paddr == OFF_CMD && pwdata[CMD_TX_RESET] && loop_ff == LOOP_NORMAL
      |=> serial_out_pin [*2];
  endproperty
  a_txrst: assert property (p_txrst) else $error("line low after tx reset");
endmodule // debug_serial_ctrl_monitor
bind debug_serial_ctrl debug_serial_ctrl_monitor u_debug_serial_ctrl_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .serial_in_pin,
  .serial_out_pin, .rx_buf_filled, .dcc_host_wrote, .dcc_core_wrote, .irq
);

// file: dv/serial_terminal_model.sv
// Remote terminal model on the far end of the serial line
`timescale 1ns/1ps
module serial_terminal_model (
  input wire logic pclk,
  input wire logic line_in,
  output logic line_out,
  output logic got_stb,
  output logic [9:0] got
);
  logic [9:0] sh;
  initial begin
    line_out = 1'b1;
    got_stb = 1'b0;
    got = 10'h0;
  end
  // ====
  // Sender: sixteen clocks a bit, as with divider one
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      line_out <= f[i];
      repeat (15) @(posedge pclk);
    end
    @(posedge pclk);
    line_out <= 1'b1;
  endtask
  // ====
  // Receiver: a start gone by mid-bit is a glitch and is dropped
  always begin
    @(negedge line_in);
    repeat (8) @(posedge pclk);
    if (line_in === 1'b0) begin
      for (int i = 0; i < 10; i++) begin
        repeat (16) @(posedge pclk);
        sh[i] = line_in;
      end
      got <= sh;
      got_stb <= 1'b1;
      @(posedge pclk);
      got_stb <= 1'b0;
    end
  end
endmodule // serial_terminal_model

// file: dv/tb_debug_uart_control_regs.sv
// Self-checking bench for the debug serial port control registers
`timescale 1ns/1ps
module tb_debug_uart_control_regs;
  import dbg_serial_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] side = 6'h00;
  logic [31:0] prdata, m, r;
  logic pready, pslverr, sin, sout, irq, got_stb;
  logic [9:0] got;
  logic [2:0] ctype = 3'h0;
  logic [71:0] note;
  logic [71:0] rdq[$];
  logic [9:0] txq[$];
  int err_total = 0;
  int checks = 0;
  integer seed = 32'hB263E41B;
  always #4 pclk = ~pclk;
  debug_serial_ctrl u_debug_serial_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_in_pin(sin), .serial_out_pin(sout), .rx_xfer_done(side[0]),
    .tx_xfer_done(side[1]), .tx_buf_drained(side[2]), .rx_buf_filled(side[3]),
    .dcc_host_wrote(side[4]), .dcc_core_wrote(side[5]), .irq
  );
  serial_terminal_model u_serial_terminal_model (
    .pclk, .line_in(sout), .line_out(sin), .got_stb, .got
  );
  // ====
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    rdq.push_back({a, e & k, k});
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] lv(input logic [5:0] s);
    return {s[4], s[5], 17'h0, s[3], s[2], 6'h0, s[1], s[0], 3'h0};
  endfunction
  // Sampled frame: eight data bits, then check or stop, then stop or idle
  function automatic logic [9:0] frm(input logic [7:0] v);
    logic c;
    c = ctype[1] ? ctype[0] : (^v ^ ctype[0]);
    return ctype[2] ? {2'h3, v} : {1'b1, c, v};
  endfunction
  task automatic tx(input logic [7:0] v);
    txq.push_back(frm(v));
    wr(OFF_TXH, {24'h0, v});
  endtask
  task automatic snd(input logic [7:0] v, input logic bad_ck, input logic bad_stop);
    logic [9:0] f;
    f = frm(v);
    f[8] = f[8] ^ (bad_ck & ~ctype[2]);
    f[ctype[2] ? 8 : 9] = ~bad_stop;
    u_serial_terminal_model.send({f, 1'b0}, ctype[2] ? 10 : 11);
    repeat (16) @(posedge pclk);
  endtask
  task automatic snd_cmd(input logic [7:0] v, input logic [31:0] c);
    fork
      snd(v, 1'b0, 1'b0);
      begin
        repeat (60) @(posedge pclk);
        wr(OFF_CMD, c);
      end
    join
  endtask
  // ====
  // Result watchers
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      note = rdq.pop_front();
      check($sformatf("read %h", note[71:64]), prdata & note[31:0], note[63:32]);
      check("slverr", 32'(pslverr), 32'(note[71:64] inside {[8'h24:8'h3C]}));
    end
    if (got_stb === 1'b1) begin
      if (txq.size() == 0) check("extra frame", {22'h0, got}, ALL);
      else check("frame", {22'h0, got}, {22'h0, txq.pop_front()});
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
  // ====
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CFG, 32'h0, ALL);
    rd(OFF_RXH, 32'h0, ALL);
    wr(OFF_IMASK, ALL);
    rd(OFF_IMASK, 32'h0, ALL);
    rd(8'h30, 32'h0, ALL);
    $display("reset test done");
    m = 32'h0;
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk) side <= 6'($random(seed));
      r = $random(seed);
      wr(OFF_IRQ_SET, r);
      m = m | (r & IRQ_VALID);
      rd(OFF_IMASK, m, ALL);
      r = $random(seed);
      wr(OFF_IRQ_CLR, r);
      m = m & ~r;
      rd(OFF_IMASK, m, ALL);
      rd(OFF_FLAGS, lv(side), 32'hC000_1818);
      #1 check("irq", {31'h0, irq}, {31'h0, |(lv(side) & m)});
    end
    wr(OFF_IRQ_SET, ALL);
    side <= 6'h3F;
    rd(OFF_FLAGS, 32'hC000_1818, 32'hC000_1818);
    #1 check("irq raised", {31'h0, irq}, 32'h1);
    wr(OFF_IRQ_CLR, ALL);
    #1 check("irq masked", {31'h0, irq}, 32'h0);
    @(posedge pclk) side <= 6'h00;
    $display("interrupt test done");
    wr(OFF_BAUD, 32'h1);
    wr(OFF_CMD, 32'h50);
    rd(OFF_FLAGS, 32'h202, 32'h2E3);
    // Back-to-back characters only where a check bit keeps the frames apart
    for (int k = 0; k < 5; k++) begin
      ctype = k[2:0];
      wr(OFF_CFG, 32'(ctype) << CFG_CHECK_LSB);
      rd(OFF_CFG, 32'(ctype) << CFG_CHECK_LSB, ALL);
      tx(8'($random(seed)));
      if (!ctype[2]) tx(8'($random(seed)));
      repeat (400) @(posedge pclk);
    end
    ctype = 3'h0;
    wr(OFF_CFG, 32'h0);
    tx(8'h00);
    tx(8'hFF);
    wr(OFF_CMD, 32'h80);
    rd(OFF_FLAGS, 32'h0, 32'h200);
    repeat (400) @(posedge pclk);
    rd(OFF_FLAGS, 32'h0, 32'h202);
    wr(OFF_TXH, 32'hA5);
    wr(OFF_CMD, 32'hC0);
    rd(OFF_FLAGS, 32'h0, 32'h202);
    $display("transmit test done");
    snd(8'h3C, 1'b0, 1'b0);
    rd(OFF_FLAGS, 32'h1, 32'hE1);
    rd(OFF_RXH, 32'h3C, ALL);
    snd(8'h11, 1'b1, 1'b0);
    snd(8'h22, 1'b0, 1'b1);
    snd(8'h33, 1'b0, 1'b0);
    wr(OFF_CMD, 32'h0);
    rd(OFF_FLAGS, 32'hE0, 32'hE0);
    wr(OFF_CMD, 32'h100);
    rd(OFF_FLAGS, 32'h0, 32'hE0);
    rd(OFF_RXH, 32'h33, ALL);
    snd_cmd(8'h5A, 32'h20);
    rd(OFF_RXH, 32'h5A, ALL);
    wr(OFF_CMD, 32'h30);
    snd(8'h6B, 1'b0, 1'b0);
    rd(OFF_FLAGS, 32'h0, 32'h1);
    wr(OFF_CMD, 32'h10);
    snd_cmd(8'h7E, 32'h04);
    rd(OFF_FLAGS, 32'h0, 32'h1);
    rd(OFF_RXH, 32'h5A, ALL);
    $display("receive test done");
    wr(OFF_CMD, 32'h50);
    wr(OFF_CFG, 32'h4000);
    txq.push_back(frm(8'h96));
    snd(8'h96, 1'b0, 1'b0);
    wr(OFF_CFG, 32'h8000);
    wr(OFF_TXH, 32'hC3);
    repeat (200) @(posedge pclk);
    rd(OFF_RXH, 32'hC3, ALL);
    wr(OFF_CFG, 32'hC000);
    rd(OFF_CFG, 32'hC000, ALL);
    txq.push_back(frm(8'h69));
    snd(8'h69, 1'b0, 1'b0);
    wr(OFF_CFG, 32'h0);
    wr(OFF_TXH, 32'h81);
    wr(OFF_CMD, 32'h08);
    repeat (300) @(posedge pclk);
    check("frames left", 32'(txq.size()), 32'h0);
    $display("loop and abort test done");
    report_and_stop();
  end
endmodule // tb_debug_uart_control_regs
